// file: common/btx_consts.svh
// Purpose: Constants of the bit and transfer instruction executer.
// Assumes: 16-bit instruction words, 32 working registers of 8 bits.
// Notes: Opcodes are matched as (word & MASK) == MATCH.
// How it works
// - Compare with constant subtracts, keeps no result, sets Z N V C H, one clock.
// - Register bit clear skips next instruction; one, two or three clocks.
// - I/O bit set skips next instruction; one to three clocks, no flag change.
// - Flag bit clear branches to PC plus offset plus one; one or two clocks.
// - Transfer flag clear branches relative; one or two clocks, flags untouched.
// - I/O bit set and clear write one bit, two clocks, no flag change.
// - Rotate left through carry, updates Z C N V, one clock.
// - Rotate right through carry, updates Z C N V, one clock.
// - Bit store copies a register bit into the transfer flag, one clock.
// - Bit load copies the transfer flag into a register bit, one clock.
// - Single flag set and clear touch only the addressed flag, one clock.
// - Half carry clear writes zero to that flag only, one clock.
// - Indirect load post-increment reads at pointer then adds one; two clocks.
// - Indirect load pre-decrement subtracts one then reads; two clocks.
// - Displaced load reads pointer plus displacement, pointer kept; two clocks.
// - Direct load reads an immediate address, two clocks, no flag change.
// - Indirect store post-increment writes at pointer then adds one; two clocks.
// - Displaced store writes pointer plus displacement, pointer kept; two clocks.
// - Direct store writes an immediate address, two clocks, no flag change.
// - Program memory load post-increment reads byte at third pointer; three clocks.
`ifndef BTX_CONSTS_SVH
`define BTX_CONSTS_SVH
`define BTX_M_LDI      16'hf000
`define BTX_V_LDI      16'he000
`define BTX_V_CPI      16'h3000
`define BTX_M_SKIPREG  16'hfe08
`define BTX_V_SKIP_ON_REG_BIT_CLEAR     16'hfc00
`define BTX_M_IOBYTE   16'hff00
`define BTX_V_SKIP_ON_IO_BIT_SET     16'h9b00
`define BTX_V_SBI      16'h9a00
`define BTX_V_CBI      16'h9800
`define BTX_M_BRANCH_ON_FLAG_CLEAR     16'hfc00
`define BTX_V_BRANCH_ON_FLAG_CLEAR     16'hf400
`define BTX_V_ADC      16'h1c00
`define BTX_M_ROR      16'hfe0f
`define BTX_V_ROR      16'h9407
`define BTX_V_BST      16'hfa00
`define BTX_V_BLD      16'hf800
`define BTX_M_FLAG     16'hff8f
`define BTX_V_BSET     16'h9408
`define BTX_V_BCLR     16'h9488
`define BTX_M_MEMOP    16'hfe00
`define BTX_V_LDGRP    16'h9000
`define BTX_V_STGRP    16'h9200
`define BTX_M_DISP     16'hd000
`define BTX_V_DISP     16'h8000
`define BTX_M_TWOW_A   16'hfc0f
`define BTX_V_TWOW_A   16'h9000
`define BTX_M_TWOW_B   16'hfe0c
`define BTX_V_TWOW_B   16'h940c
`define BTX_PTR_X      2'h0
`define BTX_PTR_Y      2'h1
`define BTX_PTR_Z      2'h2
`define BTX_RST_PC     16'h0000
`define BTX_RST_FLAGS  8'h00
`define BTX_RST_REG    8'h00
`endif

// file: common/btx_pkg.sv
// Purpose: Types shared by the instruction executer files.
// Assumes: Constants come from btx_consts.svh.
// Notes: Flag layout follows the flag register bit order, bit 7 first.
package btx_pkg;
   typedef struct packed {
      logic i;
      logic t;
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } btx_flags_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic re;
      logic we;
   } btx_dmem_req_t;
   typedef struct packed {
      logic [5:0] addr;
      logic [2:0] bitn;
      logic set;
      logic clr;
   } btx_io_req_t;
   typedef enum logic [1:0] {BTX_ALU_CMP, BTX_ALU_ROL, BTX_ALU_ROR} btx_alu_op_t;
endpackage : btx_pkg

// file: design/btx_alu.sv
// Purpose: Compare and rotate datapath with flag results.
// Assumes: Purely combinational; caller chooses when flags are stored.
// Notes: Flags that an operation does not own pass through unchanged.
`timescale 1ns/1ps
module btx_alu
   import btx_pkg::*;
(
   // Operation
   input wire btx_alu_op_t i_op,
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_k,
   input wire btx_flags_t i_flags,
   // Result
   output logic [7:0] o_res,
   output btx_flags_t o_flags
);
   always_comb
   begin
      o_flags = i_flags;
      o_res = i_a;
      unique case (i_op)
         BTX_ALU_CMP:
         begin
            o_res = i_a - i_k;
            o_flags.h = (~i_a[3] & i_k[3]) | (i_k[3] & o_res[3]) | (o_res[3] & ~i_a[3]);
            o_flags.v = (i_a[7] & ~i_k[7] & ~o_res[7]) | (~i_a[7] & i_k[7] & o_res[7]);
            o_flags.c = (~i_a[7] & i_k[7]) | (i_k[7] & o_res[7]) | (o_res[7] & ~i_a[7]);
         end
         BTX_ALU_ROL:
         begin
            o_res = {i_a[6:0], i_flags.c};
            o_flags.h = i_a[3];
            o_flags.c = i_a[7];
            o_flags.v = o_res[7] ^ i_a[7];
         end
         BTX_ALU_ROR:
         begin
            o_res = {i_flags.c, i_a[7:1]};
            o_flags.c = i_a[0];
            o_flags.v = o_res[7] ^ i_a[0];
         end
         default:
         begin
            o_res = i_a;
         end
      endcase
      o_flags.n = o_res[7];
      o_flags.z = (o_res == 8'h00);
      o_flags.s = o_flags.n ^ o_flags.v;
   end
endmodule : btx_alu

// file: design/btx_regfile.sv
// Purpose: Working register file with the three pointer pairs.
// Assumes: Byte and pair writes never target the same register in one cycle.
// Notes: Read data come straight from the storage flops, so reads are same cycle.
`timescale 1ns/1ps
`include "btx_consts.svh"
module btx_regfile
   import btx_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Byte write
   input wire logic i_we,
   input wire logic [4:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // Pointer pair write
   input wire logic i_pwe,
   input wire logic [1:0] i_psel,
   input wire logic [15:0] i_pdata,
   // Reads
   input wire logic [4:0] i_raddr,
   output logic [7:0] o_rdata,
   output logic [15:0] o_ptr_x,
   output logic [15:0] o_ptr_y,
   output logic [15:0] o_ptr_z
);
   logic [7:0] regs [32];
   for (genvar g = 0; g < 32; g++)
   begin : g_reg
      localparam logic [4:0] IDX = 5'(g);
      always_ff @(posedge i_core_clk)
      begin
         if (i_sys_rst)
            regs[g] <= `BTX_RST_REG;
         else if (i_pwe && IDX[4:1] == 4'(4'hd + {2'h0, i_psel}))
            regs[g] <= IDX[0] ? i_pdata[15:8] : i_pdata[7:0];
         else if (i_we && i_waddr == IDX)
            regs[g] <= i_wdata;
      end
   end
   assign o_rdata = regs[i_raddr];
   assign o_ptr_x = {regs[27], regs[26]};
   assign o_ptr_y = {regs[29], regs[28]};
   assign o_ptr_z = {regs[31], regs[30]};
endmodule : btx_regfile

// file: design/btx_core.sv
// Purpose: Executes compare, skip, branch, bit, rotate and transfer instructions.
// Assumes: Memories answer combinationally in the cycle after the request flops.
// Notes: Unknown opcodes retire as one-clock no-ops.
`timescale 1ns/1ps
`include "btx_consts.svh"
module btx_core
   import btx_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Instruction stream
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [15:0] i_instr_next,
   output logic o_instr_ready,
   output logic [15:0] o_pc,
   // Data memory
   output btx_dmem_req_t o_dmem,
   input wire logic [7:0] i_dmem_rdata,
   // I/O space
   output logic [5:0] o_io_raddr,
   input wire logic [7:0] i_io_rdata,
   output btx_io_req_t o_io,
   // Program memory
   output logic [15:0] o_pmem_addr,
   output logic o_pmem_re,
   input wire logic [7:0] i_pmem_rdata,
   // Status
   output btx_flags_t o_flags
);
   typedef enum logic [4:0] {
      OP_NOP, OP_LDI, OP_CPI, OP_SKIP_ON_REG_BIT_CLEAR, OP_SKIP_ON_IO_BIT_SET, OP_SBI, OP_CBI, OP_BRANCH_ON_FLAG_CLEAR, OP_ROL,
      OP_ROR, OP_BST, OP_BLD, OP_BSET, OP_BCLR, OP_LD, OP_ST, OP_LPM
   } btx_op_t;
   typedef enum logic [2:0] {
      ST_EXEC, ST_MEM, ST_PM_WAIT, ST_PM_DONE, ST_SKIP1, ST_SKIP2, ST_BRANCH, ST_IO
   } btx_state_t;

   btx_state_t state;
   btx_op_t op;
   logic accept;
   logic [4:0] rsel;
   logic [4:0] dest;
   logic [7:0] rval;
   logic [7:0] flag_vec;
   logic [7:0] kimm;
   logic [2:0] bitn;
   logic [1:0] psel;
   logic ptr_inc;
   logic ptr_dec;
   logic direct;
   logic [5:0] disp;
   logic [15:0] ptr_val;
   logic [15:0] mem_addr;
   logic next_word_two;
   logic skip;
   logic taken;
   logic [15:0] next_pc;
   logic [7:0] alu_res;
   btx_flags_t alu_flags;
   btx_alu_op_t alu_op;
   logic [15:0] ptr_x;
   logic [15:0] ptr_y;
   logic [15:0] ptr_z;
   logic rf_we;
   logic [4:0] rf_waddr;
   logic [7:0] rf_wdata;
   logic rf_pwe;
   logic [15:0] rf_pdata;
   logic [4:0] pend_dest;
   logic [7:0] pm_byte;

   assign o_instr_ready = (state == ST_EXEC);
   assign accept = i_instr_valid && o_instr_ready;
   assign flag_vec = o_flags;

   // Decode
   always_comb
   begin
      op = OP_NOP;
      psel = `BTX_PTR_Z;
      ptr_inc = 1'b0;
      ptr_dec = 1'b0;
      direct = 1'b0;
      disp = 6'h00;
      if ((i_instr & `BTX_M_LDI) == `BTX_V_LDI)
         op = OP_LDI;
      else if ((i_instr & `BTX_M_LDI) == `BTX_V_CPI)
         op = OP_CPI;
      else if ((i_instr & `BTX_M_SKIPREG) == `BTX_V_SKIP_ON_REG_BIT_CLEAR)
         op = OP_SKIP_ON_REG_BIT_CLEAR;
      else if ((i_instr & `BTX_M_IOBYTE) == `BTX_V_SKIP_ON_IO_BIT_SET)
         op = OP_SKIP_ON_IO_BIT_SET;
      else if ((i_instr & `BTX_M_IOBYTE) == `BTX_V_SBI)
         op = OP_SBI;
      else if ((i_instr & `BTX_M_IOBYTE) == `BTX_V_CBI)
         op = OP_CBI;
      else if ((i_instr & `BTX_M_BRANCH_ON_FLAG_CLEAR) == `BTX_V_BRANCH_ON_FLAG_CLEAR)
         op = OP_BRANCH_ON_FLAG_CLEAR;
      else if ((i_instr & `BTX_M_BRANCH_ON_FLAG_CLEAR) == `BTX_V_ADC && {i_instr[9], i_instr[3:0]} == i_instr[8:4])
         op = OP_ROL;
      else if ((i_instr & `BTX_M_ROR) == `BTX_V_ROR)
         op = OP_ROR;
      else if ((i_instr & `BTX_M_SKIPREG) == `BTX_V_BST)
         op = OP_BST;
      else if ((i_instr & `BTX_M_SKIPREG) == `BTX_V_BLD)
         op = OP_BLD;
      else if ((i_instr & `BTX_M_FLAG) == `BTX_V_BSET)
         op = OP_BSET;
      else if ((i_instr & `BTX_M_FLAG) == `BTX_V_BCLR)
         op = OP_BCLR;
      else if ((i_instr & `BTX_M_DISP) == `BTX_V_DISP)
      begin
         op = i_instr[9] ? OP_ST : OP_LD;
         psel = i_instr[3] ? `BTX_PTR_Y : `BTX_PTR_Z;
         disp = {i_instr[13], i_instr[11:10], i_instr[2:0]};
      end
      else if ((i_instr & `BTX_M_MEMOP) == `BTX_V_LDGRP
               || (i_instr & `BTX_M_MEMOP) == `BTX_V_STGRP)
      begin
         op = i_instr[9] ? OP_ST : OP_LD;
         psel = (i_instr[3:2] == 2'h3) ? `BTX_PTR_X
              : (i_instr[3] ? `BTX_PTR_Y : `BTX_PTR_Z);
         unique case (i_instr[3:0])
            4'h0: direct = 1'b1;
            4'h1, 4'h9, 4'hd: ptr_inc = 1'b1;
            4'h2, 4'ha, 4'he: ptr_dec = 1'b1;
            4'hc: ptr_inc = 1'b0;
            4'h4, 4'h5:
            begin
               op = i_instr[9] ? OP_NOP : OP_LPM;
               ptr_inc = i_instr[0];
            end
            default: op = OP_NOP;
         endcase
      end
   end

   // Immediate forms only reach the upper sixteen registers
   assign rsel = (op == OP_CPI || op == OP_LDI) ? {1'b1, i_instr[7:4]} : i_instr[8:4];
   assign dest = rsel;
   assign kimm = {i_instr[11:8], i_instr[3:0]};
   assign bitn = i_instr[2:0];
   assign o_io_raddr = {1'b0, i_instr[7:3]};

   // Pointer address forming
   always_comb
   begin
      unique case (psel)
         `BTX_PTR_X: ptr_val = ptr_x;
         `BTX_PTR_Y: ptr_val = ptr_y;
         default: ptr_val = ptr_z;
      endcase
   end
   assign mem_addr = direct ? i_instr_next
                   : ptr_dec ? ptr_val - 16'h0001
                   : ptr_val + {10'h000, disp};

   // Skip and branch decisions
   assign next_word_two = ((i_instr_next & `BTX_M_TWOW_A) == `BTX_V_TWOW_A)
                        || ((i_instr_next & `BTX_M_TWOW_B) == `BTX_V_TWOW_B);
   assign skip = (op == OP_SKIP_ON_REG_BIT_CLEAR && !rval[bitn])
              || (op == OP_SKIP_ON_IO_BIT_SET && i_io_rdata[bitn]);
   assign taken = (op == OP_BRANCH_ON_FLAG_CLEAR) && !flag_vec[bitn];

   always_comb
   begin
      next_pc = o_pc + 16'h0001;
      if (taken)
         next_pc = o_pc + {{9{i_instr[9]}}, i_instr[9:3]} + 16'h0001;
      else if (skip)
         next_pc = o_pc + (next_word_two ? 16'h0003 : 16'h0002);
      else if (direct && (op == OP_LD || op == OP_ST))
         next_pc = o_pc + 16'h0002;
   end

   always_comb
   begin
      unique case (op)
         OP_ROL: alu_op = BTX_ALU_ROL;
         OP_ROR: alu_op = BTX_ALU_ROR;
         default: alu_op = BTX_ALU_CMP;
      endcase
   end

   btx_alu u_alu (
      .i_op(alu_op),
      .i_a(rval),
      .i_k(kimm),
      .i_flags(o_flags),
      .o_res(alu_res),
      .o_flags(alu_flags)
   );

   // Register file write steering
   always_comb
   begin
      rf_we = 1'b0;
      rf_waddr = dest;
      rf_wdata = alu_res;
      if (state == ST_MEM && !o_dmem.we)
      begin
         rf_we = 1'b1;
         rf_waddr = pend_dest;
         rf_wdata = i_dmem_rdata;
      end
      else if (state == ST_PM_DONE)
      begin
         rf_we = 1'b1;
         rf_waddr = pend_dest;
         rf_wdata = pm_byte;
      end
      else if (accept)
      begin
         unique case (op)
            OP_LDI: 
            begin
               rf_we = 1'b1;
               rf_wdata = kimm;
            end
            OP_ROL, OP_ROR: rf_we = 1'b1;
            OP_BLD:
            begin
               rf_we = 1'b1;
               rf_wdata = rval;
               rf_wdata[bitn] = o_flags.t;
            end
            default: rf_we = 1'b0;
         endcase
      end
   end
   assign rf_pwe = accept && (op == OP_LD || op == OP_ST || op == OP_LPM)
                && (ptr_inc || ptr_dec);
   assign rf_pdata = ptr_dec ? mem_addr : ptr_val + 16'h0001;

   btx_regfile u_regfile (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_we(rf_we),
      .i_waddr(rf_waddr),
      .i_wdata(rf_wdata),
      .i_pwe(rf_pwe),
      .i_psel(psel),
      .i_pdata(rf_pdata),
      .i_raddr(rsel),
      .o_rdata(rval),
      .o_ptr_x(ptr_x),
      .o_ptr_y(ptr_y),
      .o_ptr_z(ptr_z)
   );

   // Sequencing
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         state <= ST_EXEC;
      else
         unique case (state)
            ST_EXEC:
               if (accept)
               begin
                  if (op == OP_LD || op == OP_ST)
                     state <= ST_MEM;
                  else if (op == OP_LPM)
                     state <= ST_PM_WAIT;
                  else if (op == OP_SBI || op == OP_CBI)
                     state <= ST_IO;
                  else if (taken)
                     state <= ST_BRANCH;
                  else if (skip)
                     state <= next_word_two ? ST_SKIP2 : ST_SKIP1;
               end
            ST_SKIP2: state <= ST_SKIP1;
            ST_PM_WAIT: state <= ST_PM_DONE;
            default: state <= ST_EXEC;
         endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_pc <= `BTX_RST_PC;
      else if (accept)
         o_pc <= next_pc;
   end

   // Flag updates; anything not named here keeps its value
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_flags <= `BTX_RST_FLAGS;
      else if (accept)
         unique case (op)
            OP_CPI, OP_ROL, OP_ROR: o_flags <= alu_flags;
            OP_BST: o_flags.t <= rval[bitn];
            OP_BSET: o_flags <= flag_vec | (8'h01 << i_instr[6:4]);
            OP_BCLR: o_flags <= flag_vec & ~(8'h01 << i_instr[6:4]);
            default: o_flags <= o_flags;
         endcase
   end

   // Memory and I/O requests stand for exactly the second clock
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_dmem <= '0;
         pend_dest <= 5'h00;
      end
      else if (accept && (op == OP_LD || op == OP_ST))
      begin
         o_dmem.addr <= mem_addr;
         o_dmem.wdata <= rval;
         o_dmem.re <= (op == OP_LD);
         o_dmem.we <= (op == OP_ST);
         pend_dest <= dest;
      end
      else
      begin
         o_dmem.re <= 1'b0;
         o_dmem.we <= 1'b0;
         if (accept && op == OP_LPM)
            pend_dest <= dest;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_io <= '0;
      else if (accept && (op == OP_SBI || op == OP_CBI))
      begin
         o_io.addr <= o_io_raddr;
         o_io.bitn <= bitn;
         o_io.set <= (op == OP_SBI);
         o_io.clr <= (op == OP_CBI);
      end
      else
      begin
         o_io.set <= 1'b0;
         o_io.clr <= 1'b0;
      end
   end

   // Program memory byte read, held one clock before write-back
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_pmem_addr <= 16'h0000;
         o_pmem_re <= 1'b0;
         pm_byte <= 8'h00;
      end
      else
      begin
         o_pmem_re <= accept && (op == OP_LPM);
         if (accept && op == OP_LPM)
            o_pmem_addr <= ptr_z;
         if (state == ST_PM_WAIT)
            pm_byte <= i_pmem_rdata;
      end
   end

   // Checks
   chk_cpi_one_clock: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_CPI |=> o_instr_ready && o_pc == $past(o_pc) + 16'h0001
         && o_flags.z == ($past(rval) == $past(kimm)))
      else $error("compare did not retire in one clock with correct zero");
   chk_skip_on_reg_bit_clear_skip: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_SKIP_ON_REG_BIT_CLEAR && !rval[bitn] && !next_word_two |=> !o_instr_ready ##1 o_instr_ready)
      else $error("register bit skip took wrong clocks");
   chk_skip_on_io_bit_set_pc: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_SKIP_ON_IO_BIT_SET && i_io_rdata[bitn]
      |=> o_pc >= $past(o_pc) + 16'h0002 && o_pc <= $past(o_pc) + 16'h0003 && $stable(o_flags))
      else $error("io bit skip moved pc wrongly");
   chk_branch_taken: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && taken |=> !o_instr_ready && $stable(o_flags) ##1 o_instr_ready)
      else $error("taken branch not two clocks");
   chk_iobit_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_SBI |=> o_io.set && !o_io.clr ##1 !o_io.set && o_instr_ready)
      else $error("io bit set not a two clock operation");
   chk_rol_carry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_ROL |=> o_flags.c == $past(rval[7]) && o_instr_ready)
      else $error("rotate left carry wrong");
   chk_ror_carry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_ROR |=> o_flags.c == $past(rval[0]) && o_instr_ready)
      else $error("rotate right carry wrong");
   chk_bst_only_t: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_BST |=> {o_flags.i, o_flags.h, o_flags.s, o_flags.v, o_flags.n,
         o_flags.z, o_flags.c} == $past({o_flags.i, o_flags.h, o_flags.s, o_flags.v,
         o_flags.n, o_flags.z, o_flags.c}))
      else $error("bit store changed another flag");
   chk_load_two_clk: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_LD |=> o_dmem.re && !o_instr_ready ##1 !o_dmem.re && o_instr_ready)
      else $error("load not two clocks");
   chk_store_two_clk: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_ST |=> o_dmem.we && o_dmem.wdata == $past(rval) ##1 !o_dmem.we)
      else $error("store strobe wrong");
   chk_lpm_three_clk: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      accept && op == OP_LPM |=> !o_instr_ready [*2] ##1 o_instr_ready)
      else $error("program memory load not three clocks");
   cov_skip_two_word: cover property (@(posedge i_core_clk) accept && skip && next_word_two);
   cov_branch_taken: cover property (@(posedge i_core_clk) accept && taken);
   cov_lpm_inc: cover property (@(posedge i_core_clk) accept && op == OP_LPM && ptr_inc);
   cov_predec_load: cover property (@(posedge i_core_clk) accept && op == OP_LD && ptr_dec);
endmodule : btx_core

// file: dv/btx_mem_model.sv
// Purpose: Data memory, I/O space and program memory seen by the executer.
// Assumes: Reads answer combinationally in the strobe cycle.
// Notes: Idle read lines show inverted data, so a late sample never matches.
`timescale 1ns/1ps
module btx_mem_model
   import btx_pkg::*;
(
   // Core side
   input wire logic i_core_clk,
   input wire btx_dmem_req_t i_dmem,
   input wire btx_io_req_t i_io,
   input wire logic [5:0] i_io_raddr,
   input wire logic [15:0] i_pmem_addr,
   input wire logic i_pmem_re,
   // Answers
   output logic [7:0] o_dmem_rdata,
   output logic [7:0] o_io_rdata,
   output logic [7:0] o_pmem_rdata
);
   logic [7:0] dmem [512];
   logic [7:0] io [64] = '{default: 8'h00};
   initial
   begin
      for (int i = 0; i < 512; i++)
         dmem[i] = 8'(i) ^ 8'h3c;
   end
   always @(posedge i_core_clk)
   begin
      if (i_dmem.we)
         dmem[i_dmem.addr[8:0]] <= i_dmem.wdata;
      if (i_io.set)
         io[i_io.addr][i_io.bitn] <= 1'b1;
      if (i_io.clr)
         io[i_io.addr][i_io.bitn] <= 1'b0;
   end
   assign o_dmem_rdata = i_dmem.re ? dmem[i_dmem.addr[8:0]] : ~dmem[i_dmem.addr[8:0]];
   assign o_io_rdata = io[i_io_raddr];
   // Byte pattern differs when idle so a missing strobe is caught
   assign o_pmem_rdata = (i_pmem_re ? 8'ha5 : 8'h5a) ^ i_pmem_addr[7:0];
endmodule : btx_mem_model

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the bit and transfer executer.
// Assumes: Memory model preloaded with address xor 3c.
// Notes: Registers are observed by storing them to memory.
`timescale 1ns/1ps
module tb_top
   import btx_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic vld = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [15:0] nxw = 16'h0000;
   logic rdy;
   logic pm_re;
   logic [15:0] pc, pm_a;
   logic [7:0] dm_rd, io_rd, pm_rd, rv;
   logic [5:0] io_ra;
   btx_dmem_req_t dm;
   btx_io_req_t io;
   btx_flags_t fl;
   logic [24:0] notes[$];
   logic [24:0] seen;
   logic [15:0] epc = 16'h0000;
   logic [7:0] ef = 8'h00;
   int n_fail = 0;
   int n_compared = 0;
   btx_core u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(instr),
      .i_instr_next(nxw), .o_instr_ready(rdy), .o_pc(pc), .o_dmem(dm), .i_dmem_rdata(dm_rd),
      .o_io_raddr(io_ra), .i_io_rdata(io_rd), .o_io(io), .o_pmem_addr(pm_a),
      .o_pmem_re(pm_re), .i_pmem_rdata(pm_rd), .o_flags(fl));
   btx_mem_model u_mem (.i_core_clk(clk), .i_dmem(dm), .i_io(io), .i_io_raddr(io_ra),
      .i_pmem_addr(pm_a), .i_pmem_re(pm_re), .o_dmem_rdata(dm_rd), .o_io_rdata(io_rd),
      .o_pmem_rdata(pm_rd));
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   task automatic final_report();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Valid stays up while refused, so back-to-back words need no extra edge
   task automatic run(input logic [15:0] w, input logic [15:0] nx, input int clks, input int dpc);
      int n;
      n = 1;
      instr = w;
      nxw = nx;
      vld = 1'b1;
      @(negedge clk);
      while (rdy !== 1'b1 && n < 8)
      begin
         n++;
         @(negedge clk);
      end
      epc = epc + 16'(dpc);
      chk("clocks", 25'(clks), 25'(n));
      chk("pc", 25'(epc), 25'(pc));
      chk("flags", 25'(ef), 25'(fl));
      if (rdy !== 1'b1)
         final_report();
   endtask : run
   task automatic nt(input logic [15:0] a, input logic [7:0] v);
      notes.push_back({1'b0, a, v});
   endtask : nt
   task automatic ldi(input logic [4:0] d, input logic [7:0] k);
      run({4'he, k[7:4], d[3:0], k[3:0]}, 16'h0000, 1, 1);
   endtask : ldi
   task automatic sts(input logic [4:0] r, input logic [15:0] k, input logic [7:0] v);
      nt(k, v);
      run(16'h9200 | {7'h00, r, 4'h0}, k, 2, 2);
   endtask : sts
   always @(negedge clk)
   begin
      if (dm.we === 1'b1 || io.set === 1'b1 || io.clr === 1'b1)
      begin
         seen = dm.we === 1'b1 ? {1'b0, dm.addr, dm.wdata} : {1'b1, 13'h0000, io};
         chk("strobe", notes.size() > 0 ? notes.pop_front() : 25'h0000000, seen);
      end
   end
   initial
   begin
      void'($urandom(19328));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk("reset pc", 25'h0, 25'(pc));
      @(negedge clk);
      ldi(16, 8'h7f);
      ef = 8'h0d;
      run(16'h3f0f, 16'h0000, 1, 1);
      ef = 8'h2c;
      run(16'h1f00, 16'h0000, 1, 1);
      sts(16, 16'h0100, 8'hff);
      ef = 8'h39;
      run(16'h9507, 16'h0000, 1, 1);
      sts(16, 16'h0101, 8'h7f);
      $display("test rotate done");
      for (int s = 0; s < 8; s++)
      begin
         ef[s] = 1'b1;
         run(16'h9408 | 16'(s << 4), 16'h0000, 1, 1);
         ef[s] = 1'b0;
         run(16'h9488 | 16'(s << 4), 16'h0000, 1, 1);
      end
      ef = 8'h40;
      run(16'hfb00, 16'h0000, 1, 1);
      run(16'hf913, 16'h0000, 1, 1);
      sts(17, 16'h0102, 8'h08);
      run(16'hf42e, 16'h0000, 1, 1);
      ef = 8'h00;
      run(16'hfb10, 16'h0000, 1, 1);
      run(16'hf42e, 16'h0000, 2, 6);
      run(16'hf7e9, 16'h0000, 2, -2);
      ef = 8'h02;
      run(16'h9418, 16'h0000, 1, 1);
      run(16'hf7e9, 16'h0000, 1, 1);
      $display("test flags done");
      run(16'hfd10, 16'h0000, 2, 2);
      run(16'hfd10, 16'h9300, 3, 3);
      run(16'hfd13, 16'h0000, 1, 1);
      notes.push_back({1'b1, 13'h0000, 6'h05, 3'h2, 2'b10});
      run(16'h9a2a, 16'h0000, 2, 1);
      run(16'h9b2a, 16'h9300, 3, 3);
      notes.push_back({1'b1, 13'h0000, 6'h05, 3'h2, 2'b01});
      run(16'h982a, 16'h0000, 2, 1);
      run(16'h9b2a, 16'h0000, 1, 1);
      $display("test skip done");
      ldi(26, 8'hff);
      ldi(27, 8'h00);
      run(16'h910d, 16'h0000, 2, 1);
      nt(16'h0100, 8'hc3);
      run(16'h930d, 16'h0000, 2, 1);
      run(16'h910e, 16'h0000, 2, 1);
      sts(16, 16'h0110, 8'hc3);
      nt(16'h0100, 8'hc3);
      run(16'h930d, 16'h0000, 2, 1);
      ldi(28, 8'h20);
      ldi(29, 8'h01);
      run(16'h810d, 16'h0000, 2, 1);
      nt(16'h0127, 8'h19);
      run(16'h830f, 16'h0000, 2, 1);
      nt(16'h0121, 8'h19);
      run(16'h8309, 16'h0000, 2, 1);
      run(16'h9110, 16'h0030, 2, 2);
      sts(17, 16'h0131, 8'h0c);
      ldi(30, 8'hff);
      ldi(31, 8'h00);
      run(16'h9105, 16'h0000, 3, 1);
      sts(16, 16'h0140, 8'h5a);
      run(16'h9111, 16'h0000, 2, 1);
      nt(16'h0101, 8'hc3);
      run(16'h9311, 16'h0000, 2, 1);
      for (int i = 0; i < 4; i++)
      begin
         rv = 8'($urandom);
         ldi(18, rv);
         sts(18, 16'h0150 + 16'(i), rv);
      end
      $display("test memory done");
      vld = 1'b0;
      chk("pending", 25'h0, 25'(notes.size()));
      final_report();
   end
   initial
   begin
      #100000;
      n_fail++;
      final_report();
   end
endmodule : tb_top
